// [design/ptsic_pkg.sv]
package ptsic_pkg;
   // ****************************************************************
   // field widths
   // ****************************************************************
   localparam int unsigned OFFS_W    = 16;   // insertion and checksum offsets
   localparam int unsigned TAG_W     = 16;   // timestamp tag
   localparam int unsigned TIMER_W   = 80;   // system timer and timestamps
   localparam int unsigned LANE_W    = 5;    // pcs lane number
   localparam int unsigned SEG_W     = 4;    // local bus segments
   localparam int unsigned ADJ_W     = 16;   // lane adjustment amount
   localparam int unsigned FIFO_AW   = 2;    // tag fifo index width
   localparam int unsigned FIFO_D    = 4;    // tag fifo depth
   localparam int unsigned WB_AW     = 8;    // wishbone byte address width

   // ****************************************************************
   // operation select encoding
   // ****************************************************************
   localparam logic [1:0] OP_NONE    = 2'h0;
   localparam logic [1:0] OP_ONE     = 2'h1;
   localparam logic [1:0] OP_TWO     = 2'h2;
   localparam logic [1:0] OP_RSVD    = 2'h3;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
   localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [WB_AW-1:0] REG_MASK   = 8'h08;
   localparam logic [WB_AW-1:0] REG_STEP   = 8'h0c;
   localparam logic [WB_AW-1:0] REG_RXTS0  = 8'h10;
   localparam logic [WB_AW-1:0] REG_RXTS1  = 8'h14;
   localparam logic [WB_AW-1:0] REG_RXTS2  = 8'h18;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int unsigned CTRL_LANE_ADJ = 0;  // lane adjustment enable
   localparam int unsigned CTRL_TC_MODE  = 1;  // transparent clock mode
   localparam int unsigned ST_WR_ERR     = 0;  // tag write error event
   localparam int unsigned ST_RD_ERR     = 1;  // tag read error event
   localparam int unsigned ST_RX_TS      = 2;  // receive timestamp captured
   localparam int unsigned ST_W          = 3;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [1:0]       CTRL_RST = 2'h0;
   localparam logic [ST_W-1:0]  MASK_RST = 3'h0;
   localparam logic [ADJ_W-1:0] STEP_RST = 16'h0000;
endpackage : ptsic_pkg

// [design/ptsic_tag_fifo.sv]
`timescale 1ns/100ps
module ptsic_tag_fifo
   import ptsic_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             push_i,
   input  wire logic [TAG_W-1:0] push_tag_i,
   input  wire logic             pop_i,
   output logic                  valid_o,
   output logic [TAG_W-1:0]      tag_o,
   output logic                  wr_err_o,
   output logic                  rd_err_o
);
   logic [TAG_W-1:0]   mem_ff [FIFO_D];
   logic [TAG_W-1:0]   nxt_mem [FIFO_D];
   logic [FIFO_AW-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [FIFO_AW-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [FIFO_AW:0]   cnt_ff, nxt_cnt;
   logic               full, empty, do_push, do_pop;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      full       = (cnt_ff == FIFO_D[FIFO_AW:0]);
      empty      = (cnt_ff == '0);
      do_pop     = pop_i & ~empty;
      do_push    = push_i & (~full | do_pop);
      nxt_mem    = mem_ff;
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_cnt    = cnt_ff;
      if (do_push) begin
         nxt_mem[wr_ptr_ff] = push_tag_i;
         nxt_wr_ptr         = wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
         nxt_rd_ptr = rd_ptr_ff + 1'b1;
      end
      nxt_cnt  = cnt_ff + {{FIFO_AW{1'b0}}, do_push} - {{FIFO_AW{1'b0}}, do_pop};
      wr_err_o = push_i & ~do_push;   // tag dropped: fifo full
      rd_err_o = pop_i & empty;       // tag requested from empty fifo
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
         for (int i = 0; i < FIFO_D; i++) begin
            mem_ff[i] <= '0;
         end
      end else if (ce_i) begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         cnt_ff    <= nxt_cnt;
         mem_ff    <= nxt_mem;
      end
   end

   assign valid_o = (cnt_ff != '0);
   assign tag_o   = mem_ff[rd_ptr_ff];
endmodule : ptsic_tag_fifo

// [design/ptsic_top.sv]
// Behaviour
// - single-step timestamp inserted at client byte offset
// - offset ignored for no-op and two-step
// - full sixteen-bit offset, covers jumbo frames
// - lane adjust on: correct by sop lane
// - lane adjust touches single-step frames only
// - tag write error sticky until tx reset
// - tag read error sticky until tx reset
// - rx timestamp valid with local bus sop
// - rx timestamp keeps timer input layout
// - operation select decode, reserved acts as none
// - checksum update bit requests udp recalculation on single-step frames only
`timescale 1ns/100ps
module ptsic_top
   import ptsic_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   // wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [WB_AW-1:0]   wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   output logic                    irq_o,
   // transmit per-frame controls
   input  wire logic               tx_path_rst_i,
   input  wire logic               tx_sop_i,
   input  wire logic [LANE_W-1:0]  tx_sop_lane_i,
   input  wire logic [1:0]         tx_timestamp_op_sel_i,
   input  wire logic [OFFS_W-1:0]  tx_tstamp_offset_i,
   input  wire logic [TAG_W-1:0]   tx_tag_i,
   input  wire logic               tx_upd_chksum_i,
   input  wire logic [OFFS_W-1:0]  tx_chksum_offset_i,
   input  wire logic               tx_tag_pop_i,
   // transmit insertion command to the frame editor
   output logic                    tx_ins_valid_o,
   output logic [OFFS_W-1:0]       tx_ins_offset_o,
   output logic                    tx_ins_corr_o,
   output logic                    tx_ins_chksum_o,
   output logic [OFFS_W-1:0]       tx_ins_chksum_offset_o,
   output logic [ADJ_W-1:0]        tx_ins_adjust_o,
   output logic                    tx_two_step_o,
   // transmit tag return and error status
   output logic                    tx_tag_valid_o,
   output logic [TAG_W-1:0]        tx_tag_o,
   output logic                    tx_fifo_write_error_o,
   output logic                    tx_fifo_read_error_o,
   // receive timestamp
   input  wire logic [TIMER_W-1:0] rx_systemtimer_i,
   input  wire logic               rx_capture_i,
   input  wire logic [LANE_W-1:0]  rx_capture_lane_i,
   input  wire logic [SEG_W-1:0]   rx_sop_seg_i,
   output logic [TIMER_W-1:0]      rx_tstamp_o,
   output logic [LANE_W-1:0]       rx_pcslane_o,
   output logic                    rx_tstamp_valid_o
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic op_is_one(input logic [1:0] op);
      return (op == OP_ONE);
   endfunction : op_is_one

   function automatic logic op_is_two(input logic [1:0] op);
      return (op == OP_TWO);
   endfunction : op_is_two

   function automatic logic [ADJ_W-1:0] lane_adjust(input logic [LANE_W-1:0] lane,
                                                    input logic [ADJ_W-1:0]  step);
      logic [ADJ_W+LANE_W-1:0] prod;
      prod = step * lane;
      return prod[ADJ_W-1:0];
   endfunction : lane_adjust

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [1:0]         ctrl_ff,   nxt_ctrl;
   logic [ST_W-1:0]    status_ff, nxt_status;
   logic [ST_W-1:0]    mask_ff,   nxt_mask;
   logic [ADJ_W-1:0]   step_ff,   nxt_step;
   logic               ack_ff,    nxt_ack;
   logic [31:0]        rdat_ff,   nxt_rdat;
   logic               ins_valid_ff, nxt_ins_valid;
   logic [OFFS_W-1:0]  ins_offset_ff, nxt_ins_offset;
   logic               ins_corr_ff, nxt_ins_corr;
   logic               ins_chk_ff, nxt_ins_chk;
   logic [OFFS_W-1:0]  ins_chk_off_ff, nxt_ins_chk_off;
   logic [ADJ_W-1:0]   ins_adj_ff, nxt_ins_adj;
   logic               two_ff, nxt_two;
   logic               wr_err_ff, nxt_wr_err;
   logic               rd_err_ff, nxt_rd_err;
   logic [TIMER_W-1:0] rx_ts_ff, nxt_rx_ts;
   logic [LANE_W-1:0]  rx_lane_ff, nxt_rx_lane;
   logic               rx_have_ff, nxt_rx_have;
   logic               bus_req, bus_wr;
   logic               tx_take, tag_push;
   logic               fifo_wr_err, fifo_rd_err;
   logic               fifo_rst;

   assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign bus_wr   = bus_req & wb_we_i;
   assign tx_take  = tx_sop_i;
   assign tag_push = tx_take & (op_is_one(tx_timestamp_op_sel_i) | op_is_two(tx_timestamp_op_sel_i));
   assign fifo_rst = rst_i | tx_path_rst_i;

   // ****************************************************************
   // tag fifo
   // ****************************************************************
   ptsic_tag_fifo u_tag_fifo (
      .clk_i      (clk_i),
      .rst_i      (fifo_rst),
      .ce_i       (ce_i),
      .push_i     (tag_push),
      .push_tag_i (tx_tag_i),
      .pop_i      (tx_tag_pop_i),
      .valid_o    (tx_tag_valid_o),
      .tag_o      (tx_tag_o),
      .wr_err_o   (fifo_wr_err),
      .rd_err_o   (fifo_rd_err)
   );

   // ****************************************************************
   // register file next state
   // ****************************************************************
   always_comb begin
      nxt_ctrl   = ctrl_ff;
      nxt_mask   = mask_ff;
      nxt_step   = step_ff;
      nxt_status = status_ff;
      nxt_ack    = bus_req;
      nxt_rdat   = 32'h0000_0000;
      // write-one-to-clear first, hardware set afterwards so a set wins
      if (bus_wr && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
         nxt_status = status_ff & ~wb_dat_i[ST_W-1:0];
      end
      if (bus_wr && wb_sel_i[0]) begin
         if (wb_adr_i == REG_CTRL) begin
            nxt_ctrl = wb_dat_i[1:0];
         end else if (wb_adr_i == REG_MASK) begin
            nxt_mask = wb_dat_i[ST_W-1:0];
         end
      end
      if (bus_wr && wb_adr_i == REG_STEP) begin
         if (wb_sel_i[0]) begin
            nxt_step[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            nxt_step[15:8] = wb_dat_i[15:8];
         end
      end
      if (fifo_wr_err) begin
         nxt_status[ST_WR_ERR] = 1'b1;
      end
      if (fifo_rd_err) begin
         nxt_status[ST_RD_ERR] = 1'b1;
      end
      if (rx_capture_i) begin
         nxt_status[ST_RX_TS] = 1'b1;
      end
      // read data mux, unmapped addresses read zero
      if (bus_req && !wb_we_i) begin
         if (wb_adr_i == REG_CTRL) begin
            nxt_rdat = {30'h0, ctrl_ff};
         end else if (wb_adr_i == REG_STATUS) begin
            nxt_rdat = {29'h0, status_ff};
         end else if (wb_adr_i == REG_MASK) begin
            nxt_rdat = {29'h0, mask_ff};
         end else if (wb_adr_i == REG_STEP) begin
            nxt_rdat = {16'h0, step_ff};
         end else if (wb_adr_i == REG_RXTS0) begin
            nxt_rdat = rx_ts_ff[31:0];
         end else if (wb_adr_i == REG_RXTS1) begin
            nxt_rdat = rx_ts_ff[63:32];
         end else if (wb_adr_i == REG_RXTS2) begin
            nxt_rdat = {16'h0, rx_ts_ff[79:64]};
         end
      end
   end

   // ****************************************************************
   // register file registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff   <= CTRL_RST;
         mask_ff   <= MASK_RST;
         step_ff   <= STEP_RST;
         status_ff <= '0;
         ack_ff    <= 1'b0;
         rdat_ff   <= 32'h0000_0000;
      end else if (ce_i) begin
         ctrl_ff   <= nxt_ctrl;
         mask_ff   <= nxt_mask;
         step_ff   <= nxt_step;
         status_ff <= nxt_status;
         ack_ff    <= nxt_ack;
         rdat_ff   <= nxt_rdat;
      end
   end

   // ****************************************************************
   // transmit command next state
   // ****************************************************************
   always_comb begin
      nxt_ins_valid   = 1'b0;
      nxt_ins_offset  = ins_offset_ff;
      nxt_ins_corr    = ins_corr_ff;
      nxt_ins_chk     = ins_chk_ff;
      nxt_ins_chk_off = ins_chk_off_ff;
      nxt_ins_adj     = ins_adj_ff;
      nxt_two         = 1'b0;
      if (tx_take) begin
         nxt_two = op_is_two(tx_timestamp_op_sel_i);
         if (op_is_one(tx_timestamp_op_sel_i)) begin
            nxt_ins_valid   = 1'b1;
            nxt_ins_offset  = tx_tstamp_offset_i;
            nxt_ins_corr    = ctrl_ff[CTRL_TC_MODE];
            nxt_ins_chk     = tx_upd_chksum_i;
            nxt_ins_chk_off = tx_upd_chksum_i ? tx_chksum_offset_i : '0;
            nxt_ins_adj     = ctrl_ff[CTRL_LANE_ADJ] ?
                              lane_adjust(tx_sop_lane_i, step_ff) : '0;
         end else begin
            // offset and adjustment unused outside single-step
            nxt_ins_offset  = '0;
            nxt_ins_corr    = 1'b0;
            nxt_ins_chk     = 1'b0;
            nxt_ins_chk_off = '0;
            nxt_ins_adj     = '0;
         end
      end
   end

   // ****************************************************************
   // transmit command registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || tx_path_rst_i) begin
         ins_valid_ff   <= 1'b0;
         ins_offset_ff  <= '0;
         ins_corr_ff    <= 1'b0;
         ins_chk_ff     <= 1'b0;
         ins_chk_off_ff <= '0;
         ins_adj_ff     <= '0;
         two_ff         <= 1'b0;
      end else if (ce_i) begin
         ins_valid_ff   <= nxt_ins_valid;
         ins_offset_ff  <= nxt_ins_offset;
         ins_corr_ff    <= nxt_ins_corr;
         ins_chk_ff     <= nxt_ins_chk;
         ins_chk_off_ff <= nxt_ins_chk_off;
         ins_adj_ff     <= nxt_ins_adj;
         two_ff         <= nxt_two;
      end
   end

   // ****************************************************************
   // sticky tag fifo errors, cleared only by rst_i or a tx path reset
   // ****************************************************************
   always_comb begin
      nxt_wr_err = wr_err_ff | fifo_wr_err;
      nxt_rd_err = rd_err_ff | fifo_rd_err;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || tx_path_rst_i) begin
         wr_err_ff <= 1'b0;
         rd_err_ff <= 1'b0;
      end else if (ce_i) begin
         wr_err_ff <= nxt_wr_err;
         rd_err_ff <= nxt_rd_err;
      end
   end

   // ****************************************************************
   // receive timestamp capture
   // ****************************************************************
   always_comb begin
      nxt_rx_ts   = rx_ts_ff;
      nxt_rx_lane = rx_lane_ff;
      nxt_rx_have = rx_have_ff;
      if (rx_capture_i) begin
         nxt_rx_ts   = rx_systemtimer_i;
         nxt_rx_lane = rx_capture_lane_i;
         nxt_rx_have = 1'b1;
      end else if (|rx_sop_seg_i) begin
         nxt_rx_have = 1'b0;                              // consumed by the sop
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_ts_ff   <= '0;
         rx_lane_ff <= '0;
         rx_have_ff <= 1'b0;
      end else if (ce_i) begin
         rx_ts_ff   <= nxt_rx_ts;
         rx_lane_ff <= nxt_rx_lane;
         rx_have_ff <= nxt_rx_have;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign wb_dat_o               = rdat_ff;
   assign wb_ack_o               = ack_ff;
   assign irq_o                  = |(status_ff & mask_ff);
   assign tx_ins_valid_o         = ins_valid_ff;
   assign tx_ins_offset_o        = ins_offset_ff;
   assign tx_ins_corr_o          = ins_corr_ff;
   assign tx_ins_chksum_o        = ins_chk_ff;
   assign tx_ins_chksum_offset_o = ins_chk_off_ff;
   assign tx_ins_adjust_o        = ins_adj_ff;
   assign tx_two_step_o          = two_ff;
   assign tx_fifo_write_error_o  = wr_err_ff;
   assign tx_fifo_read_error_o   = rd_err_ff;
   assign rx_tstamp_o            = rx_ts_ff;
   assign rx_pcslane_o           = rx_lane_ff;
   assign rx_tstamp_valid_o      = rx_have_ff & (|rx_sop_seg_i);
endmodule : ptsic_top

// [tb/ptsic_client_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// far-side timer source, runs on the lane zero receive clock
// ****************************************************************
module ptsic_client_model
   import ptsic_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          tc_mode_i,
   output logic [TIMER_W-1:0] timer_o
);
   logic [47:0] sec_ff, nxt_sec;
   logic [31:0] ns_ff, nxt_ns;
   // advance 100 ns a cycle, roll seconds at one billion
   always_comb begin
      nxt_ns  = ns_ff + 32'h64;
      nxt_sec = sec_ff;
      if (ns_ff >= 32'h3b9ac99c) begin
         nxt_ns  = 32'h0;
         nxt_sec = sec_ff + 48'h1;
      end
   end
   // same clock as the block: lane zero domain
   always_ff @(posedge clk_i) begin
      sec_ff <= rst_i ? 48'h0000_0001_2345 : nxt_sec;
      ns_ff  <= rst_i ? 32'h3b9a_c000 : nxt_ns;
   end
   // layout per clock mode
   assign timer_o = tc_mode_i ? {16'h0, 1'b0, 15'h0, ns_ff, 16'h8000} : {sec_ff, ns_ff};
endmodule : ptsic_client_model

// [tb/ptsic_top_assertions.sv]
`timescale 1ns/100ps
module ptsic_top_assertions
   import ptsic_pkg::*;
(
   input wire logic clk_i, rst_i, ce_i, tx_path_rst_i, tx_sop_i, tx_upd_chksum_i,
   input wire logic [1:0] tx_timestamp_op_sel_i,
   input wire logic [OFFS_W-1:0] tx_tstamp_offset_i, tx_chksum_offset_i,
   input wire logic tx_ins_valid_o, tx_ins_chksum_o, tx_two_step_o, tx_tag_valid_o,
   input wire logic [OFFS_W-1:0] tx_ins_offset_o, tx_ins_chksum_offset_o,
   input wire logic [ADJ_W-1:0] tx_ins_adjust_o,
   input wire logic tx_fifo_write_error_o, tx_fifo_read_error_o, rx_capture_i, rx_tstamp_valid_o,
   input wire logic [TIMER_W-1:0] rx_systemtimer_i, rx_tstamp_o,
   input wire logic [SEG_W-1:0] rx_sop_seg_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ****************************************************************
   // frame start and capture events
   // ****************************************************************
   sequence s_sop(logic [1:0] op);
      ce_i && tx_sop_i && tx_timestamp_op_sel_i == op;
   endsequence
   sequence s_cap;
      ce_i && rx_capture_i;
   endsequence
   a_one_step_cmd: assert property (s_sop(OP_ONE) |=> tx_ins_valid_o && !tx_two_step_o &&
      tx_ins_offset_o == $past(tx_tstamp_offset_i)) else $error("one-step command wrong");
   a_two_step_cmd: assert property (s_sop(OP_TWO) |=> tx_two_step_o && !tx_ins_valid_o &&
      tx_ins_offset_o == '0) else $error("two-step command wrong");
   a_no_op_cmd: assert property (s_sop(OP_NONE) or s_sop(OP_RSVD) |=>
      !tx_ins_valid_o && !tx_two_step_o) else $error("no-op gave command");
   a_adj_one_only: assert property (ce_i && tx_sop_i && tx_timestamp_op_sel_i != OP_ONE
      |=> tx_ins_adjust_o == '0) else $error("adjust outside one-step");
   a_chksum_req: assert property (s_sop(OP_ONE) |=> tx_ins_chksum_o == $past(tx_upd_chksum_i)
      && tx_ins_chksum_offset_o == ($past(tx_upd_chksum_i) ? $past(tx_chksum_offset_i) : '0))
      else $error("checksum request wrong");
   a_wr_err_hold: assert property (tx_fifo_write_error_o && !tx_path_rst_i |=> tx_fifo_write_error_o)
      else $error("write error dropped");
   a_rd_err_hold: assert property (tx_fifo_read_error_o && !tx_path_rst_i |=> $stable(tx_fifo_read_error_o))
      else $error("read error dropped");
   a_path_clear: assert property (ce_i && tx_path_rst_i |=> !tx_fifo_write_error_o &&
      !tx_fifo_read_error_o && !tx_tag_valid_o) else $error("tx reset did not clear");
   a_rx_capture: assert property (s_cap |=> rx_tstamp_o == $past(rx_systemtimer_i))
      else $error("rx timestamp wrong");
   a_rx_valid_sop: assert property (s_cap ##1 (!rx_capture_i && rx_sop_seg_i != '0) |-> rx_tstamp_valid_o)
      else $error("rx valid missing");
endmodule : ptsic_top_assertions
bind ptsic_top ptsic_top_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .tx_path_rst_i(tx_path_rst_i), .tx_sop_i(tx_sop_i), .tx_upd_chksum_i(tx_upd_chksum_i),
   .tx_timestamp_op_sel_i(tx_timestamp_op_sel_i), .tx_tstamp_offset_i(tx_tstamp_offset_i),
   .tx_chksum_offset_i(tx_chksum_offset_i), .tx_ins_valid_o(tx_ins_valid_o), .tx_ins_chksum_o(tx_ins_chksum_o),
   .tx_two_step_o(tx_two_step_o), .tx_tag_valid_o(tx_tag_valid_o), .tx_ins_offset_o(tx_ins_offset_o),
   .tx_ins_chksum_offset_o(tx_ins_chksum_offset_o), .tx_ins_adjust_o(tx_ins_adjust_o),
   .tx_fifo_write_error_o(tx_fifo_write_error_o), .tx_fifo_read_error_o(tx_fifo_read_error_o),
   .rx_capture_i(rx_capture_i), .rx_tstamp_valid_o(rx_tstamp_valid_o), .rx_systemtimer_i(rx_systemtimer_i),
   .rx_tstamp_o(rx_tstamp_o), .rx_sop_seg_i(rx_sop_seg_i));

// [tb/ptsic_top_tb.sv]
`timescale 1ns/100ps
module ptsic_top_tb;
   import ptsic_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, prst = 1'b0, sop = 1'b0;
   logic upd = 1'b0, pop = 1'b0, cap = 1'b0, tc = 1'b0, ce = 1'b1;
   logic ack, irq, ivld, icorr, ichk, two, tvld, werr, rerr, rvld;
   logic [WB_AW-1:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, rd, dat;
   logic [1:0] op = 2'h0;
   logic [LANE_W-1:0] lane = 5'h0, rlane, clane = 5'h7;
   logic [OFFS_W-1:0] offs = 16'h0, coffs = 16'h0, ioffs, icoffs;
   logic [TAG_W-1:0] tag = 16'h0, tago;
   logic [ADJ_W-1:0] iadj;
   logic [SEG_W-1:0] seg = 4'h0;
   logic [TIMER_W-1:0] tmr, rts, exp_ts;
   int err_count = 0, check_count = 0, cycles = 0;
   always #50 clk = ~clk;
   ptsic_top u_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .irq_o(irq),
      .tx_path_rst_i(prst), .tx_sop_i(sop), .tx_sop_lane_i(lane), .tx_timestamp_op_sel_i(op),
      .tx_tstamp_offset_i(offs), .tx_tag_i(tag), .tx_upd_chksum_i(upd), .tx_chksum_offset_i(coffs),
      .tx_tag_pop_i(pop), .tx_ins_valid_o(ivld), .tx_ins_offset_o(ioffs), .tx_ins_corr_o(icorr),
      .tx_ins_chksum_o(ichk), .tx_ins_chksum_offset_o(icoffs), .tx_ins_adjust_o(iadj), .tx_two_step_o(two),
      .tx_tag_valid_o(tvld), .tx_tag_o(tago), .tx_fifo_write_error_o(werr), .tx_fifo_read_error_o(rerr),
      .rx_systemtimer_i(tmr), .rx_capture_i(cap), .rx_capture_lane_i(clane), .rx_sop_seg_i(seg),
      .rx_tstamp_o(rts), .rx_pcslane_o(rlane), .rx_tstamp_valid_o(rvld));
   ptsic_client_model u_model (.clk_i(clk), .rst_i(rst), .tc_mode_i(tc), .timer_o(tmr));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task chk(input logic [95:0] seen, input logic [95:0] expv);
      check_count++;
      if (seen !== expv) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask : chk
   // classic single cycle, held until ack is sampled
   task wb(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rd = dat;
      {cyc, stb, we} <= 3'h0;
   endtask : wb
   // one frame start, offset f as given, coffs = 16'h0030, upd = ~lane[0]
   task tx(input logic [1:0] o, input logic [OFFS_W-1:0] f, input logic [LANE_W-1:0] l, input logic [TAG_W-1:0] t);
      @(posedge clk);
      {sop, op, offs, lane, tag, upd, coffs} <= {1'b1, o, f, l, t, ~l[0], 16'h0030};
      @(posedge clk);
      sop <= 1'b0;
      @(negedge clk);
   endtask : tx
   task pulse(input logic p);
      @(posedge clk);
      if (p) prst <= 1'b1; else pop <= 1'b1;
      @(posedge clk);
      {prst, pop} <= 2'h0;
      @(negedge clk);
   endtask : pulse
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task t_ops;
      for (int i = 0; i < 4; i++) begin
         tx(i[1:0], 16'hfffe, 5'h0, 16'h0);
         chk(ivld, i == 1);
         chk(two, i == 2);
         chk(ioffs, (i == 1) ? 16'hfffe : 16'h0);
         chk(ichk, i == 1);
         chk(icoffs, (i == 1) ? 16'h0030 : 16'h0);
         @(negedge clk);
         chk(ivld, 1'b0);
      end
      $display("t_ops done");
   endtask : t_ops
   task t_lane;
      wb(1'b0, REG_STEP, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, REG_STEP, 32'h3);
      wb(1'b1, REG_CTRL, 32'h1);
      tx(OP_ONE, 16'h0016, 5'h5, 16'h1);
      chk(iadj, 16'h000f);
      chk(ichk, 1'b0);
      tx(OP_TWO, 16'h0016, 5'h5, 16'h2);
      chk(iadj, 16'h0);
      wb(1'b1, REG_CTRL, 32'h2);
      tx(OP_ONE, 16'h0040, 5'h5, 16'h3);
      chk({icorr, ioffs, iadj}, {1'b1, 16'h0040, 16'h0});
      wb(1'b1, REG_CTRL, 32'h0);
      $display("t_lane done");
   endtask : t_lane
   task t_fifo;
      wb(1'b1, REG_STATUS, 32'h7);
      pulse(1'b1);
      chk({werr, rerr, tvld}, 3'h0);
      for (int i = 0; i < 5; i++) tx(OP_TWO, 16'h0, 5'h0, TAG_W'(16'h00a0 + i));
      chk(werr, 1'b1);
      @(posedge clk) ce <= 1'b0;
      pulse(1'b0);
      chk({tvld, tago}, {1'b1, 16'h00a0});
      @(posedge clk) ce <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         chk({tvld, tago}, {1'b1, TAG_W'(16'h00a0 + i)});
         pulse(1'b0);
      end
      pulse(1'b0);
      repeat (4) @(negedge clk);
      chk({tvld, werr, rerr}, 3'h3);
      wb(1'b0, REG_STATUS, 32'h0);
      chk({irq, rd[2:0]}, 4'h3);
      wb(1'b1, REG_MASK, 32'h3);
      @(negedge clk) chk(irq, 1'b1);
      wb(1'b1, REG_STATUS, 32'h3);
      @(negedge clk) chk({irq, werr}, 2'h1);
      pulse(1'b1);
      chk({werr, rerr}, 2'h0);
      wb(1'b1, REG_MASK, 32'h0);
      $display("t_fifo done");
   endtask : t_fifo
   task t_rx;
      for (int m = 0; m < 2; m++) begin
         wb(1'b1, REG_CTRL, 32'(m * 2));
         tc <= m[0];
         @(posedge clk) cap <= 1'b1;
         @(negedge clk) exp_ts = tmr;
         @(posedge clk) {cap, seg} <= {1'b0, 4'h2};
         @(negedge clk) chk({rvld, rlane, rts}, {1'b1, 5'h7, exp_ts});
         @(posedge clk) seg <= 4'h1;
         @(negedge clk) chk(rvld, 1'b0);
         @(posedge clk) seg <= 4'h0;
         wb(1'b0, REG_RXTS2, 32'h0);
         chk(rd[15:0], exp_ts[79:64]);
         wb(1'b0, REG_RXTS1, 32'h0);
         chk(rd, exp_ts[63:32]);
      end
      $display("t_rx done");
   endtask : t_rx
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         finish_test();
      end
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_ops();
      t_lane();
      t_fifo();
      t_rx();
      finish_test();
   end
endmodule : ptsic_top_tb
